// *** rtl/rra_defs.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef RRA_DEFS_SVH
`define RRA_DEFS_SVH
`define RRA_OFF_MODE 8'h00
`define RRA_OFF_PULSE 8'h04
`define RRA_OFF_INTR 8'h08
`define RRA_OFF_AVG_UP 8'h0c
`define RRA_OFF_AVG_LO 8'h10
`define RRA_OFF_AVG_ROUTE 8'h14
`define RRA_OFF_AVG_DLY 8'h18
`define RRA_OFF_EXT_REF 8'h1c
`define RRA_OFF_INCLUDE 8'h20
`define RRA_OFF_RTN 8'h24
`define RRA_OFF_FOLLOW 8'h28
`define RRA_OFF_BLOCK 8'h2c
`define RRA_OFF_STATUS 8'h30
`define RRA_OFF_ACK 8'h34
`define RRA_OFF_ROUTE0 8'h40
`define RRA_OFF_ROUTE15 8'h7c
`define RRA_ROUTE_B_LSB 4
`define RRA_AVG_UPB_LSB 4
`define RRA_AVG_BLA_LSB 8
`define RRA_AVG_BLB_LSB 12
`define RRA_BLOCK_BOTH_LSB 16
`define RRA_STAT_AVG_LSB 16
`define RRA_RST_INTR 12'h003
`define RRA_MIN_INTR 12'h003
`define RRA_CLK_NS 4
`define RRA_TENTH_NS 100000000
`define RRA_TENTH_CYC (`RRA_TENTH_NS / `RRA_CLK_NS)
`define RRA_TENTHS_PER_SEC 4'h9
`endif

// *** rtl/rra_pkg.sv ***
// types shared by the realarm relay block
package rra_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rra_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rra_apb_rsp_t;
  typedef enum logic [1:0] {
    RRA_FOLLOW = 2'h0,
    RRA_MEMORY = 2'h1,
    RRA_PULSE = 2'h2,
    RRA_INTERRUPT = 2'h3
  } rra_mode_t;
  typedef struct packed {
    logic selfsup;
    logic audible;
    logic [5:0] realarm;
  } rra_relays_t;
endpackage : rra_pkg

// *** rtl/rra_relay_top.sv ***
// realarm relay routing, relay modes, audible and supervision relays, average supervisor
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`include "rra_defs.svh"
module rra_relay_top #(
  parameter int TENTH_CYC = `RRA_TENTH_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire rra_pkg::rra_apb_req_t apb_req,
  output rra_pkg::rra_apb_rsp_t apb_rsp,
  input wire logic [15:0] chan_alarm,
  input wire logic [15:0][15:0] chan_value,
  input wire logic fault_in,
  output rra_pkg::rra_relays_t relays,
  output logic [15:0] dev_suppress
);
  // reset release through two flops
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // settings registers
  logic [11:0] mode_q;
  logic [7:0] pulse_len_q;
  logic [11:0] intr_q;
  logic signed [15:0] avg_up_q, avg_lo_q;
  logic [15:0] avg_route_q;
  logic [31:0] avg_dly_q;
  logic [4:0] ext_ref_q;
  logic [15:0] include_q, rtn_q, follow_q;
  logic [31:0] block_q;
  logic [15:0][6:0] route_q;
  logic [31:0] prdata_q;

  // bus decode
  logic [7:0] addr;
  logic wr_en, setup, is_route, hit, ack_wr;
  logic [3:0] route_idx;
  assign addr = apb_req.paddr;
  assign setup = apb_req.psel & ~apb_req.penable;
  assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite & hit;
  assign is_route = (addr >= `RRA_OFF_ROUTE0) && (addr <= `RRA_OFF_ROUTE15) && (addr[1:0] == 2'h0);
  assign route_idx = addr[5:2];
  assign hit = is_route || ((addr <= `RRA_OFF_ACK) && (addr[1:0] == 2'h0));
  assign ack_wr = wr_en && (addr == `RRA_OFF_ACK) && apb_req.pwdata[0];
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~hit;
  assign apb_rsp.prdata = prdata_q;

  // register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 12'h000;
      pulse_len_q <= 8'h00;
      intr_q <= `RRA_RST_INTR;
      avg_up_q <= 16'sh0000;
      avg_lo_q <= 16'sh0000;
      avg_route_q <= 16'h0000;
      avg_dly_q <= 32'h0000_0000;
      ext_ref_q <= 5'h00;
      include_q <= 16'h0000;
      rtn_q <= 16'h0000;
      follow_q <= 16'h0000;
      block_q <= 32'h0000_0000;
      route_q <= '0;
    end else if (wr_en) begin
      unique case (addr)
        `RRA_OFF_MODE: mode_q <= apb_req.pwdata[11:0];
        `RRA_OFF_PULSE: pulse_len_q <= apb_req.pwdata[7:0];
        `RRA_OFF_INTR: intr_q <= apb_req.pwdata[11:0];
        `RRA_OFF_AVG_UP: avg_up_q <= apb_req.pwdata[15:0];
        `RRA_OFF_AVG_LO: avg_lo_q <= apb_req.pwdata[15:0];
        `RRA_OFF_AVG_ROUTE: avg_route_q <= apb_req.pwdata[15:0] & 16'h7777;
        `RRA_OFF_AVG_DLY: avg_dly_q <= apb_req.pwdata;
        `RRA_OFF_EXT_REF: ext_ref_q <= apb_req.pwdata[4:0];
        `RRA_OFF_INCLUDE: include_q <= apb_req.pwdata[15:0];
        `RRA_OFF_RTN: rtn_q <= apb_req.pwdata[15:0];
        `RRA_OFF_FOLLOW: follow_q <= apb_req.pwdata[15:0];
        `RRA_OFF_BLOCK: block_q <= apb_req.pwdata;
        default: if (is_route) route_q[route_idx] <= apb_req.pwdata[6:0] & 7'h77;
      endcase
    end
  end

  // read mux, captured in the setup cycle
  logic [31:0] rd_mux;
  logic [1:0] av_act;
  logic signed [15:0] ref_val;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (is_route) rd_mux = {25'h0, route_q[route_idx]};
    else begin
      unique case (addr)
        `RRA_OFF_MODE: rd_mux = {20'h0, mode_q};
        `RRA_OFF_PULSE: rd_mux = {24'h0, pulse_len_q};
        `RRA_OFF_INTR: rd_mux = {20'h0, intr_q};
        `RRA_OFF_AVG_UP: rd_mux = {16'h0, avg_up_q};
        `RRA_OFF_AVG_LO: rd_mux = {16'h0, avg_lo_q};
        `RRA_OFF_AVG_ROUTE: rd_mux = {16'h0, avg_route_q};
        `RRA_OFF_AVG_DLY: rd_mux = avg_dly_q;
        `RRA_OFF_EXT_REF: rd_mux = {27'h0, ext_ref_q};
        `RRA_OFF_INCLUDE: rd_mux = {16'h0, include_q};
        `RRA_OFF_RTN: rd_mux = {16'h0, rtn_q};
        `RRA_OFF_FOLLOW: rd_mux = {16'h0, follow_q};
        `RRA_OFF_BLOCK: rd_mux = block_q;
        `RRA_OFF_STATUS: rd_mux = {ref_val, 6'h00, av_act, relays};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) prdata_q <= 32'h0000_0000;
    else if (setup) prdata_q <= rd_mux;
  end

  // tenth and second ticks from the system clock
  logic [24:0] tenth_cnt_q;
  logic [3:0] sec_cnt_q;
  logic tenth, sec;
  assign tenth = (tenth_cnt_q == 25'(TENTH_CYC - 1));
  assign sec = tenth && (sec_cnt_q == `RRA_TENTHS_PER_SEC);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tenth_cnt_q <= 25'h0;
      sec_cnt_q <= 4'h0;
    end else begin
      tenth_cnt_q <= tenth ? 25'h0 : tenth_cnt_q + 25'h1;
      if (tenth) sec_cnt_q <= sec ? 4'h0 : sec_cnt_q + 4'h1;
    end
  end

  // average of average_inclusion_menu channels and reference selection
  logic signed [19:0] sum;
  logic [4:0] cnt;
  logic signed [19:0] avg_full;
  logic signed [15:0] avg_q;
  always_comb begin
    sum = 20'sh0;
    cnt = 5'h0;
    for (int c = 0; c < 16; c++) begin
      if (include_q[c]) begin
        sum = sum + 20'(signed'(chan_value[c]));
        cnt = cnt + 5'h1;
      end
    end
  end
  assign avg_full = (cnt == 5'h0) ? 20'sh0 : sum / signed'({15'h0, cnt});
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) avg_q <= 16'sh0;
    else avg_q <= avg_full[15:0];
  end
  logic ext_valid;
  assign ext_valid = (ext_ref_q != 5'h00) && (ext_ref_q <= 5'h10);
  assign ref_val = ext_valid ? chan_value[4'(ext_ref_q - 5'h1)] : avg_q;

  // average set-point conditions with response and reset delays
  logic [1:0] av_cond;
  logic [1:0][8:0] dly_cnt_q;
  assign av_cond[0] = ref_val > avg_up_q;
  assign av_cond[1] = ref_val < avg_lo_q;
  for (genvar k = 0; k < 2; k++) begin : g_avdly
    logic [7:0] target;
    assign target = av_act[k] ? avg_dly_q[16*k+8 +: 8] : avg_dly_q[16*k +: 8];
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        av_act[k] <= 1'b0;
        dly_cnt_q[k] <= 9'h0;
      end else if (av_cond[k] == av_act[k]) begin
        dly_cnt_q[k] <= 9'h0;
      end else if (dly_cnt_q[k] >= {1'b0, target}) begin
        av_act[k] <= av_cond[k];
        dly_cnt_q[k] <= 9'h0;
      end else if (sec) begin
        dly_cnt_q[k] <= dly_cnt_q[k] + 9'h1;
      end
    end
  end
  // lower set-point active suppresses deviation alarms of average_inclusion_menu channels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) dev_suppress <= 16'h0;
    else dev_suppress <= av_act[1] ? include_q : 16'h0;
  end

  // routing matrix and per relay mode logic
  logic [15:0] alarm_q;
  logic [5:0][17:0] contrib;
  logic [5:0][17:0] contrib_q;
  logic [5:0] req, rly_q;
  logic [5:0][11:0] tmr_q;
  logic [11:0] intr_eff;
  assign intr_eff = (intr_q < `RRA_MIN_INTR) ? `RRA_MIN_INTR : intr_q;
  for (genvar r = 0; r < 6; r++) begin : g_relay
    logic [2:0] sel;
    logic new_in;
    rra_pkg::rra_mode_t mode;
    assign sel = 3'(r + 1);
    assign mode = rra_pkg::rra_mode_t'(mode_q[2*r +: 2]);
    for (genvar c = 0; c < 16; c++) begin : g_ch
      logic hit_a, hit_b;
      assign hit_a = (route_q[c][2:0] == sel) & ~block_q[c];
      assign hit_b = (route_q[c][6:4] == sel);
      assign contrib[r][c] = chan_alarm[c] & (hit_a | hit_b) & ~block_q[`RRA_BLOCK_BOTH_LSB + c];
    end
    assign contrib[r][16] = av_act[0] & ((avg_route_q[2:0] == sel) | (avg_route_q[6:4] == sel));
    assign contrib[r][17] = av_act[1] & ((avg_route_q[10:8] == sel) | (avg_route_q[14:12] == sel));
    assign req[r] = |contrib[r];
    assign new_in = |(contrib[r] & ~contrib_q[r]);
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        rly_q[r] <= 1'b0;
        tmr_q[r] <= 12'h0;
        contrib_q[r] <= 18'h0;
      end else begin
        contrib_q[r] <= contrib[r];
        unique case (mode)
          rra_pkg::RRA_FOLLOW: begin
            rly_q[r] <= req[r];
            tmr_q[r] <= 12'h0;
          end
          rra_pkg::RRA_MEMORY: begin
            rly_q[r] <= req[r] | (rly_q[r] & ~ack_wr);
            tmr_q[r] <= 12'h0;
          end
          rra_pkg::RRA_PULSE: begin
            if (new_in) tmr_q[r] <= 12'({4'h0, pulse_len_q} * 12'd10);
            else if (tenth && tmr_q[r] != 12'h0) tmr_q[r] <= tmr_q[r] - 12'h1;
            rly_q[r] <= new_in ? (pulse_len_q != 8'h00) : (tmr_q[r] > 12'h1 || (tmr_q[r] == 12'h1 && !tenth));
          end
          rra_pkg::RRA_INTERRUPT: begin
            if (new_in && |contrib_q[r]) tmr_q[r] <= intr_eff;
            else if (tenth && tmr_q[r] != 12'h0) tmr_q[r] <= tmr_q[r] - 12'h1;
            rly_q[r] <= req[r] && !(new_in && |contrib_q[r]) && tmr_q[r] <= 12'h1 && (tmr_q[r] == 12'h0 || tenth);
          end
        endcase
      end
    end
  end

  // audible relay: crossing or optional return, latched until acknowledged
  logic [15:0] rise, fall;
  logic aud_q, sup_q;
  assign rise = chan_alarm & ~alarm_q & ~follow_q;
  assign fall = ~chan_alarm & alarm_q & rtn_q & ~follow_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_q <= 16'h0;
      aud_q <= 1'b0;
      sup_q <= 1'b0;
    end else begin
      alarm_q <= chan_alarm;
      aud_q <= (|rise) | (|fall) | (aud_q & ~ack_wr);
      sup_q <= ~fault_in;
    end
  end
  assign relays.realarm = rly_q;
  assign relays.audible = aud_q;
  assign relays.selfsup = sup_q;

  // checks
  chk_follow_mode: assert property (@(posedge clk) disable iff (!rst_n)
    mode_q[1:0] == 2'h0 && $stable(mode_q) |=> relays.realarm[0] == $past(req[0]))
    else $error("relay 0 not following request");
  chk_route_or: assert property (@(posedge clk) disable iff (!rst_n)
    chan_alarm[0] && route_q[0][2:0] == 3'h1 && block_q[0] == 1'b0 && block_q[16] == 1'b0 |-> req[0])
    else $error("routed alarm missing from request");
  chk_block_both: assert property (@(posedge clk) disable iff (!rst_n)
    block_q[16] |-> contrib[0][0] == 1'b0)
    else $error("blocked set-point still drives relay");
  chk_audible_set: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(chan_alarm[0]) && !follow_q[0] |=> relays.audible)
    else $error("audible relay missed a crossing");
  chk_follow_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !relays.audible && ((chan_alarm ^ alarm_q) & ~follow_q) == 16'h0 |=> !relays.audible)
    else $error("follow channel sounded audible");
  chk_supervise: assert property (@(posedge clk) disable iff (!rst_n)
    fault_in |=> !relays.selfsup)
    else $error("supervision relay energized during fault");
  chk_memory_hold: assert property (@(posedge clk) disable iff (!rst_n)
    mode_q[1:0] == 2'h1 && $stable(mode_q) && relays.realarm[0] && !ack_wr |=> relays.realarm[0])
    else $error("latched relay dropped without acknowledge");
  chk_interrupt_drop: assert property (@(posedge clk) disable iff (!rst_n)
    mode_q[1:0] == 2'h3 && $stable(mode_q) && g_relay[0].new_in && |contrib_q[0] |=> !relays.realarm[0])
    else $error("joining alarm did not interrupt relay");
  chk_ext_ref: assert property (@(posedge clk) disable iff (!rst_n)
    ext_ref_q == 5'h02 |-> ref_val == chan_value[1])
    else $error("external reference not selected");
  chk_suppress: assert property (@(posedge clk) disable iff (!rst_n)
    av_act[1] |=> dev_suppress == $past(include_q))
    else $error("deviation suppression mismatch");
  chk_sec_tick: assert property (@(posedge clk) disable iff (!rst_n)
    sec |-> tenth && sec_cnt_q == 4'h9)
    else $error("second tick not aligned to tenth");

  // tenth counter restarts after each tick
  chk_tenth_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    tenth |=> tenth_cnt_q == 25'h0)
    else $error("tenth counter did not wrap");

  // second tick never lasts two cycles
  chk_sec_single: assert property (@(posedge clk) disable iff (!rst_n)
    sec |=> !sec)
    else $error("second tick stretched");

  // acknowledge clears audible when nothing new arrives
  chk_aud_ack: assert property (@(posedge clk) disable iff (!rst_n)
    ack_wr && rise == 16'h0 && fall == 16'h0 |=> !relays.audible)
    else $error("audible relay kept after acknowledge");

  // route B of channel 0 reaches its relay
  chk_route_b: assert property (@(posedge clk) disable iff (!rst_n)
    chan_alarm[0] && route_q[0][6:4] == 3'h2 && block_q[16] == 1'b0 |-> req[1])
    else $error("route b missing from request");

  // upper average routed with route code 3 requests relay 2
  chk_avg_route: assert property (@(posedge clk) disable iff (!rst_n)
    av_act[0] && avg_route_q[2:0] == 3'h3 |-> req[2])
    else $error("average route missing from request");

  // no average_inclusion_menu channel gives a zero average
  chk_avg_empty: assert property (@(posedge clk) disable iff (!rst_n)
    include_q == 16'h0 |=> avg_q == 16'sh0)
    else $error("empty average not zero");

  // latched relay drops on acknowledge once the request is gone
  chk_memory_ack: assert property (@(posedge clk) disable iff (!rst_n)
    mode_q[1:0] == 2'h1 && ack_wr && !req[0] |=> !relays.realarm[0])
    else $error("latched relay ignored acknowledge");

  // healthy unit keeps the supervision relay energized
  chk_sup_healthy: assert property (@(posedge clk) disable iff (!rst_n)
    !fault_in |=> relays.selfsup)
    else $error("supervision relay dropped while healthy");

  // interruption time never below the floor
  chk_intr_floor: assert property (@(posedge clk) disable iff (!rst_n)
    intr_eff >= `RRA_MIN_INTR)
    else $error("interruption below minimum");

  // inactive blocking set-point releases suppression
  chk_suppress_off: assert property (@(posedge clk) disable iff (!rst_n)
    !av_act[1] |=> dev_suppress == 16'h0)
    else $error("suppression without blocking set-point");
endmodule : rra_relay_top

// *** verif/rra_chan_model.sv ***
// set-point comparator model standing on the channel side of the relay block
`timescale 1ns/100ps
module rra_chan_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic [15:0][15:0] level,
  input wire logic [15:0][15:0] limit,
  output logic [15:0] alarm,
  output logic [15:0][15:0] value
);
  logic [15:0] cmp;
  logic [15:0] cmp_q;
  // per channel crossing, signed compare of value against its limit
  always_comb begin
    for (int c = 0; c < 16; c++) begin
      cmp[c] = $signed(level[c]) > $signed(limit[c]);
    end
  end
  // a slow comparator reports one cycle late
  always_ff @(posedge clk) begin
    cmp_q <= cmp;
  end
  // outputs: crossing flags and the levels passed through unchanged as values
  assign alarm = slow ? cmp_q : cmp;
  assign value = level;
endmodule : rra_chan_model

// *** verif/tb_top.sv ***
// self-checking bench for the realarm relay block
`timescale 1ns/100ps
`include "rra_defs.svh"
module tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic fault_in = 1'b0;
  logic slow = 1'b0;
  rra_pkg::rra_apb_req_t req = '0;
  rra_pkg::rra_apb_rsp_t rsp;
  rra_pkg::rra_relays_t relays;
  logic [15:0] dev_suppress;
  logic [15:0] alarm;
  logic [15:0][15:0] value;
  logic [15:0][15:0] lvl = '0;
  logic [15:0][15:0] lim = {16{16'h0100}};
  logic [31:0] rdat;
  logic perr;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;

  // design with a short tenth-second count: one second is 100 cycles
  rra_relay_top #(.TENTH_CYC(10)) DUT (.clk(clk), .resetn(resetn), .apb_req(req), .apb_rsp(rsp),
    .chan_alarm(alarm), .chan_value(value), .fault_in(fault_in), .relays(relays), .dev_suppress(dev_suppress));
  rra_chan_model chans (.clk(clk), .slow(slow), .level(lvl), .limit(lim), .alarm(alarm), .value(value));

  // clock at 4 ns
  always #2 clk = ~clk;

  // cycle ceiling against hangs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    if (err_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer: setup, access held until pready
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= {1'b1, 1'b0, wr_en, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (rsp.pready !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t bus answer missing", $time);
      stop_test();
    end
    rdat = rsp.prdata;
    perr = rsp.pslverr;
    req <= '0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask : cy

  task automatic rly(input logic [5:0] exp);
    chk({26'h0, relays.realarm}, {26'h0, exp});
  endtask : rly

  // main sequence
  initial begin
    cy(2);
    resetn <= 1'b1;
    cy(4);
    chk({24'h0, relays}, 32'h80);
    fault_in <= 1'b1;
    cy(3);
    chk({31'h0, relays.selfsup}, 32'h0);
    fault_in <= 1'b0;
    rd(8'h38);
    chk({31'h0, perr}, 32'h1);
    rd(`RRA_OFF_INTR);
    chk(rdat, {20'h0, `RRA_RST_INTR});
    rd(`RRA_OFF_MODE);
    chk(rdat, 32'h0);
    // routes A and B of one channel, follow mode
    wr(`RRA_OFF_ROUTE0, 32'h21);
    lvl[0] <= 16'h0200;
    cy(2);
    rly(6'h03);
    chk({31'h0, relays.audible}, 32'h1);
    lvl[0] <= 16'h0000;
    cy(2);
    rly(6'h00);
    wr(`RRA_OFF_ACK, 32'h1);
    cy(2);
    chk({31'h0, relays.audible}, 32'h0);
    // blocking of route A alone, then of both routes
    wr(`RRA_OFF_BLOCK, 32'h1);
    lvl[0] <= 16'h0200;
    cy(2);
    rly(6'h02);
    wr(`RRA_OFF_BLOCK, 32'h10000);
    cy(2);
    rly(6'h00);
    lvl[0] <= 16'h0000;
    wr(`RRA_OFF_BLOCK, 32'h0);
    // interruption mode: second channel joins an active relay
    wr(8'h44, 32'h01);
    wr(`RRA_OFF_MODE, 32'h3);
    lvl[0] <= 16'h0200;
    cy(3);
    rly(6'h03);
    lvl[1] <= 16'h0200;
    cy(3);
    rly(6'h02);
    cy(50);
    rly(6'h03);
    lvl[0] <= 16'h0000;
    lvl[1] <= 16'h0000;
    // latched mode with a slow comparator
    wr(`RRA_OFF_MODE, 32'h1);
    slow <= 1'b1;
    lvl[0] <= 16'h0200;
    cy(3);
    lvl[0] <= 16'h0000;
    cy(4);
    rly(6'h01);
    wr(`RRA_OFF_ACK, 32'h1);
    cy(2);
    rly(6'h00);
    slow <= 1'b0;
    // pulse mode, two seconds
    wr(`RRA_OFF_PULSE, 32'h2);
    wr(`RRA_OFF_MODE, 32'h2);
    lvl[0] <= 16'h0200;
    cy(2);
    lvl[0] <= 16'h0000;
    cy(100);
    rly(6'h01);
    cy(150);
    rly(6'h00);
    // audible: indication-following channel, then return to normal
    wr(`RRA_OFF_ACK, 32'h1);
    wr(`RRA_OFF_FOLLOW, 32'h4);
    lvl[2] <= 16'h0200;
    cy(3);
    chk({31'h0, relays.audible}, 32'h0);
    lvl[2] <= 16'h0000;
    wr(`RRA_OFF_RTN, 32'h8);
    lvl[3] <= 16'h0200;
    cy(3);
    wr(`RRA_OFF_ACK, 32'h1);
    lvl[3] <= 16'h0000;
    cy(3);
    chk({31'h0, relays.audible}, 32'h1);
    // average of average_inclusion_menu channels and its set-points
    wr(`RRA_OFF_INCLUDE, 32'h3);
    lvl[0] <= 16'h0064;
    lvl[1] <= 16'h00c8;
    cy(3);
    rd(`RRA_OFF_STATUS);
    chk({16'h0, rdat[31:16]}, 32'h96);
    wr(`RRA_OFF_AVG_ROUTE, 32'h3);
    wr(`RRA_OFF_AVG_UP, 32'h8c);
    cy(4);
    rly(6'h04);
    wr(`RRA_OFF_AVG_UP, 32'h200);
    wr(`RRA_OFF_AVG_DLY, 32'h2);
    cy(4);
    rly(6'h00);
    wr(`RRA_OFF_AVG_UP, 32'h8c);
    cy(60);
    rly(6'h00);
    cy(160);
    rly(6'h04);
    wr(`RRA_OFF_EXT_REF, 32'h2);
    cy(3);
    rd(`RRA_OFF_STATUS);
    chk({16'h0, rdat[31:16]}, 32'hc8);
    wr(`RRA_OFF_AVG_LO, 32'h12c);
    cy(4);
    chk({16'h0, dev_suppress}, 32'h3);
    wr(`RRA_OFF_AVG_UP, 32'hfffff000);
    rd(`RRA_OFF_AVG_UP);
    chk(rdat, 32'hf000);
    stop_test();
  end
endmodule : tb_top
